// *** src/npp_pkg.sv ***
// ==========================================================
// Shared constants of the programming port
package npp_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_WLRL_MAX_NS = 1000;
  localparam int T_WLRH_MIN_NS = 3700000;
  localparam int T_WLRH_MAX_NS = 4500000;
  localparam int T_WLRH_CE_MIN_NS = 7500000;
  localparam int T_WLRH_CE_MAX_NS = 9000000;
  localparam int WLRL_MAX_CYC = T_WLRL_MAX_NS / CLK_PERIOD_NS;
  localparam int WR_BUSY_CYC = (T_WLRH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CE_BUSY_CYC = (T_WLRH_CE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 20;

  // ==========================================================
  // Parallel commands
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_FUSE_WR = 8'h40;
  localparam logic [7:0] CMD_LOCK_WR = 8'h20;
  localparam logic [7:0] CMD_FUSE_RD = 8'h04;
  localparam logic [7:0] CMD_SIG_RD = 8'h08;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;

  // ==========================================================
  // Action select codes
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;

  // ==========================================================
  // Byte select pairs {b, a}
  localparam logic [1:0] BSEL_LOW = 2'h0;
  localparam logic [1:0] BSEL_LOCK = 2'h1;
  localparam logic [1:0] BSEL_EXT = 2'h2;
  localparam logic [1:0] BSEL_HIGH = 2'h3;

  // ==========================================================
  // Serial instruction bytes and bit counter end values
  localparam logic [7:0] SER_PREFIX = 8'hac;
  localparam logic [7:0] SER_EN_B2 = 8'h53;
  localparam logic [2:0] SER_CE_B2 = 3'h4;
  localparam logic [7:0] SER_EE_WR = 8'hc0;
  localparam logic [4:0] SER_LAST_BIT = 5'h1f;
  localparam logic [2:0] SER_BYTE_END = 3'h7;

  // ==========================================================
  // Reset values and identity bytes (identity values arbitrary)
  localparam logic [7:0] FUSE_LO_RST = 8'hff;
  localparam logic [7:0] FUSE_HI_RST = 8'hff;
  localparam logic [7:0] FUSE_EXT_RST = 8'hff;
  localparam logic [7:0] LOCK_RST = 8'hff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] SIG_BYTE0 = 8'h5a;
  localparam logic [7:0] SIG_BYTE1 = 8'h3c;
  localparam logic [7:0] SIG_BYTE2 = 8'h11;
  localparam logic [7:0] CALIB_RST = 8'h80;

  // ==========================================================
  // Lock byte fields and array size
  localparam int LOCK_ONE_POS = 0;
  localparam int LOCK_TWO_POS = 1;
  localparam int BOOT_LO_POS = 2;
  localparam int BOOT_HI_POS = 5;
  localparam int EE_AW = 5;
  localparam int EE_DEPTH = 32;

endpackage

// *** src/npp_sync.sv ***
`timescale 1ns/1ps
// ==========================================================
// Two-flop synchroniser
module npp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } npp_sync_t;

  npp_sync_t st_ff;
  npp_sync_t nxt_st;

  always_comb begin
    nxt_st.meta = d;
    nxt_st.stab = st_ff.meta;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.stab;
endmodule

// *** src/npp_busy_timer.sv ***
`timescale 1ns/1ps
// ==========================================================
// Busy period counter
module npp_busy_timer
  import npp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Control
  input wire logic start,
  input wire logic [CNT_W-1:0] load_val,
  // Status
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic done;
  } npp_tmr_t;

  npp_tmr_t st_ff;
  npp_tmr_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (start) begin
      nxt_st.cnt = load_val;
    end else if (st_ff.cnt != '0) begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
      nxt_st.done = (st_ff.cnt == CNT_W'(1));
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy = (st_ff.cnt != '0);
  assign done = st_ff.done;

  // ==========================================================
  // Checks
  a_timer_load: assert property (@(posedge sys_clk) disable iff (!rstn) // R12
    start |=> st_ff.cnt == $past(load_val))
    else $error("timer did not load");
  a_timer_done: assert property (@(posedge sys_clk) disable iff (!rstn) // R13
    (st_ff.cnt == CNT_W'(1)) && !start |=> done ##1 !done)
    else $error("timer done not a single pulse");
endmodule

// *** src/npp_prog_port.sv ***
`timescale 1ns/1ps
// ==========================================================
// Programming port: parallel strobes and serial download
// Overview of operation
// R1: Fuse command, data, select a low and b high, write pulse writes extended fuse.
// R2: In a written fuse byte, zero bits program and one bits erase.
// R3: Programmer returns byte select b low after an extended fuse write.
// R4: Lock command then data; zero bits program lock bits on the write pulse.
// R5: With both main lock bits programmed, boot lock bits cannot be programmed.
// R6: Only chip erase returns programmed lock bits to unprogrammed.
// R7: Fuse and lock readback starts with its own command code.
// R8: Output enable low drives fuse low, high, extended or lock by selects.
// R9: Signature command, address zero to two, select a low: signature byte.
// R10: Signature command, address zero, select a high: calibration byte.
// R11: Ready drops within one microsecond of the write pulse falling.
// R12: Fuse, lock and array writes raise ready 3.7 to 4.5 ms later.
// R13: Chip erase raises ready 7.5 to 9 ms after the write pulse.
// R14: Serial download on clock, data in and data out only while reset low.
// R15: Serial program and erase refused until the enable instruction arrives.
// R16: Serial EEPROM write erases the byte itself within its timed cycle.
// R17: Chip erase sets every array byte to all ones.
// R18: Programmer holds serial clock low long enough for the device clock.
// R19: Programmer holds serial clock high long enough for the device clock.
// R20: Load strobe rising with action select 10 captures a command.
// R21: Load strobe rising with action 00 and select a low captures address.
// R22: Load strobe rising with action select 01 captures a data byte; the code captures it only while select a is low.
// R23: Data bus driven only while output enable is low.
module npp_prog_port
  import npp_pkg::*;
#(
  parameter int WR_CYC = WR_BUSY_CYC,
  parameter int CE_CYC = CE_BUSY_CYC
) (
  // Clocks and reset
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic spi_sck,
  // Parallel programming pins
  input wire logic prog_mode,
  input wire logic load_strobe,
  input wire logic wr_n,
  input wire logic oe_n,
  input wire logic action_select_hi,
  input wire logic action_select_lo,
  input wire logic byte_select_a,
  input wire logic byte_select_b,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic ready_flag,
  // Serial programming pins
  input wire logic prog_reset_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  // Array and status side
  input wire logic [EE_AW-1:0] ee_rd_addr,
  output logic [7:0] ee_rd_data,
  output logic flash_erase,
  output logic [7:0] fuse_low_q,
  output logic [7:0] fuse_high_q,
  output logic [7:0] fuse_ext_q,
  output logic [7:0] lock_q
);
  // ==========================================================
  // Serial clock domain
  typedef struct packed {
    logic [31:0] shift;
    logic [4:0] cnt;
    logic [7:0] echo;
  } npp_ser_t;

  typedef struct packed {
    logic [31:0] word;
    logic tgl;
  } npp_hand_t;

  npp_ser_t ser_ff;
  npp_ser_t nxt_ser;
  npp_hand_t hand_ff;
  npp_hand_t nxt_hand;
  logic miso_ff;
  logic ser_arst_n;
  logic [31:0] ser_in;

  assign ser_arst_n = rstn & ~prog_reset_n; // R14
  assign ser_in = {ser_ff.shift[30:0], spi_mosi};

  always_comb begin
    nxt_ser = ser_ff;
    nxt_hand = hand_ff;
    nxt_ser.shift = ser_in;
    nxt_ser.cnt = ser_ff.cnt + 5'h01;
    if (ser_ff.cnt[2:0] == SER_BYTE_END) begin
      nxt_ser.echo = ser_in[7:0];
    end
    if (ser_ff.cnt == SER_LAST_BIT) begin
      nxt_hand.word = ser_in;
      nxt_hand.tgl = ~hand_ff.tgl;
    end
  end

  always_ff @(posedge spi_sck or negedge ser_arst_n) begin
    if (!ser_arst_n) begin
      ser_ff <= '0;
    end else begin
      ser_ff <= nxt_ser;
    end
  end

  always_ff @(posedge spi_sck or negedge rstn) begin
    if (!rstn) begin
      hand_ff <= '0;
    end else begin
      hand_ff <= nxt_hand;
    end
  end

  // Echo of the previous byte, shifted out on the falling edge
  always_ff @(negedge spi_sck or negedge ser_arst_n) begin
    if (!ser_arst_n) begin
      miso_ff <= 1'b0;
    end else begin
      miso_ff <= ser_ff.echo[3'h7 - ser_ff.cnt[2:0]];
    end
  end

  // ==========================================================
  // Pin synchronisers
  logic s_mode, s_ls, s_wr_n, s_oe_n, s_prst_n, s_tgl;
  logic s_ahi, s_alo, s_bsa, s_bsb;
  logic [7:0] s_data;

  npp_sync #(.W(18)) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .d({prog_mode, load_strobe, wr_n, oe_n, prog_reset_n, hand_ff.tgl,
        action_select_hi, action_select_lo, byte_select_a, byte_select_b, data_in}),
    .q({s_mode, s_ls, s_wr_n, s_oe_n, s_prst_n, s_tgl,
        s_ahi, s_alo, s_bsa, s_bsb, s_data})
  );

  // ==========================================================
  // System clock state
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] addr;
    logic [7:0] dlatch;
    logic [7:0] fuse_lo;
    logic [7:0] fuse_hi;
    logic [7:0] fuse_ext;
    logic [7:0] lock;
    logic [7:0] dout;
    logic [7:0] ee_rd;
    logic doe;
    logic ready;
    logic spi_en;
    logic erase;
    logic ls_d;
    logic wr_d;
    logic tg_d;
  } npp_st_t;

  npp_st_t st_ff;
  npp_st_t nxt_st;
  logic [7:0] ee_mem [EE_DEPTH];
  logic ls_rise, wr_fall, tg_evt, ser_mode, wr_go;
  logic erase_go, ee_wr_go, tmr_start, tmr_busy, tmr_done;
  logic [CNT_W-1:0] tmr_load;
  logic [1:0] act, bsel;
  logic [7:0] lock_new;
  logic [7:0] b1, b2, b3, b4;

  assign ls_rise = s_ls & ~st_ff.ls_d;
  assign wr_fall = ~s_wr_n & st_ff.wr_d;
  assign tg_evt = s_tgl ^ st_ff.tg_d;
  assign ser_mode = ~s_prst_n & ~s_mode; // R14
  assign act = {s_ahi, s_alo};
  assign bsel = {s_bsb, s_bsa};
  assign {b1, b2, b3, b4} = hand_ff.word;
  assign wr_go = wr_fall & s_mode & st_ff.ready;

  always_comb begin
    lock_new = st_ff.lock & st_ff.dlatch; // R4 R6
    if (st_ff.lock[LOCK_ONE_POS] == 1'b0 && st_ff.lock[LOCK_TWO_POS] == 1'b0) begin
      lock_new[BOOT_HI_POS:BOOT_LO_POS] = st_ff.lock[BOOT_HI_POS:BOOT_LO_POS]; // R5
    end
  end

  always_comb begin
    nxt_st = st_ff;
    erase_go = 1'b0;
    ee_wr_go = 1'b0;
    tmr_start = 1'b0;
    tmr_load = CNT_W'(WR_CYC);
    nxt_st.ls_d = s_ls;
    nxt_st.wr_d = s_wr_n;
    nxt_st.tg_d = s_tgl;
    nxt_st.ee_rd = ee_mem[ee_rd_addr];
    // Strobe capture
    if (ls_rise && s_mode) begin
      unique case (act)
        ACT_CMD: nxt_st.cmd = s_data; // R20
        ACT_ADDR: begin
          if (!s_bsa) begin
            nxt_st.addr = s_data; // R21
          end
        end
        ACT_DATA: begin
          if (!s_bsa) begin
            nxt_st.dlatch = s_data; // R22
          end
        end
        default: ;
      endcase
    end
    // Parallel write pulse
    if (wr_go) begin
      unique case (st_ff.cmd)
        CMD_FUSE_WR: begin
          tmr_start = 1'b1;
          unique case (bsel)
            BSEL_LOW: nxt_st.fuse_lo = st_ff.dlatch; // R2
            BSEL_LOCK: nxt_st.fuse_hi = st_ff.dlatch; // R2
            BSEL_EXT: nxt_st.fuse_ext = st_ff.dlatch; // R1 R2
            default: ;
          endcase
        end
        CMD_LOCK_WR: begin
          tmr_start = 1'b1;
          nxt_st.lock = lock_new; // R4
        end
        CMD_CHIP_ERASE: begin
          tmr_start = 1'b1;
          erase_go = 1'b1;
          tmr_load = CNT_W'(CE_CYC); // R13
        end
        default: ;
      endcase
    end
    // Serial instructions
    if (!ser_mode) begin
      nxt_st.spi_en = 1'b0; // R15
    end else if (tg_evt) begin
      if (b1 == SER_PREFIX && b2 == SER_EN_B2) begin
        nxt_st.spi_en = 1'b1; // R15
      end else if (st_ff.spi_en && st_ff.ready) begin // R15
        if (b1 == SER_PREFIX && b2[7:5] == SER_CE_B2) begin
          erase_go = 1'b1;
          tmr_start = 1'b1;
          tmr_load = CNT_W'(CE_CYC);
        end else if (b1 == SER_EE_WR) begin
          ee_wr_go = 1'b1; // R16
          tmr_start = 1'b1;
        end
      end
    end
    if (erase_go) begin
      nxt_st.lock = LOCK_RST; // R6
    end
    // Ready flag
    if (tmr_start) begin
      nxt_st.ready = 1'b0; // R11
    end else if (tmr_done) begin
      nxt_st.ready = 1'b1; // R12 R13
    end
    nxt_st.erase = erase_go;
    // Read back
    nxt_st.doe = s_mode & ~s_oe_n; // R23
    nxt_st.dout = ERASED_BYTE;
    if (st_ff.cmd == CMD_FUSE_RD) begin // R7
      unique case (bsel)
        BSEL_LOW: nxt_st.dout = st_ff.fuse_lo; // R8
        BSEL_HIGH: nxt_st.dout = st_ff.fuse_hi; // R8
        BSEL_EXT: nxt_st.dout = st_ff.fuse_ext; // R8
        BSEL_LOCK: nxt_st.dout = st_ff.lock; // R8
        default: ;
      endcase
    end else if (st_ff.cmd == CMD_SIG_RD) begin
      if (s_bsa) begin
        if (st_ff.addr == 8'h00) begin
          nxt_st.dout = CALIB_RST; // R10
        end
      end else begin
        unique case (st_ff.addr)
          8'h00: nxt_st.dout = SIG_BYTE0; // R9
          8'h01: nxt_st.dout = SIG_BYTE1; // R9
          8'h02: nxt_st.dout = SIG_BYTE2; // R9
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
      st_ff.fuse_lo <= FUSE_LO_RST;
      st_ff.fuse_hi <= FUSE_HI_RST;
      st_ff.fuse_ext <= FUSE_EXT_RST;
      st_ff.lock <= LOCK_RST;
      st_ff.dout <= ERASED_BYTE;
      st_ff.ready <= 1'b1;
      st_ff.ls_d <= 1'b0;
      st_ff.wr_d <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // EEPROM array
  for (genvar i = 0; i < EE_DEPTH; i++) begin : g_ee
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        ee_mem[i] <= ERASED_BYTE;
      end else if (erase_go) begin
        ee_mem[i] <= ERASED_BYTE; // R17
      end else if (ee_wr_go && b3[EE_AW-1:0] == EE_AW'(i)) begin
        ee_mem[i] <= b4; // R16
      end
    end
  end

  npp_busy_timer u_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(tmr_start),
    .load_val(tmr_load),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // ==========================================================
  // Outputs
  assign data_out = st_ff.dout;
  assign data_oe = st_ff.doe;
  assign ready_flag = st_ff.ready;
  assign spi_miso = miso_ff;
  assign ee_rd_data = st_ff.ee_rd;
  assign flash_erase = st_ff.erase; // R17
  assign fuse_low_q = st_ff.fuse_lo;
  assign fuse_high_q = st_ff.fuse_hi;
  assign fuse_ext_q = st_ff.fuse_ext;
  assign lock_q = st_ff.lock;

  // ==========================================================
  // Checks
  sequence s_busy_hold;
    !ready_flag [*8];
  endsequence

  a_ready_drop: assert property (@(posedge sys_clk) disable iff (!rstn) // R11
    tmr_start |=> s_busy_hold)
    else $error("ready did not drop and hold after write");
  a_ready_busy: assert property (@(posedge sys_clk) disable iff (!rstn) // R12
    tmr_busy |-> !ready_flag)
    else $error("ready high while timer busy");
  a_ext_fuse: assert property (@(posedge sys_clk) disable iff (!rstn) // R1
    wr_go && st_ff.cmd == CMD_FUSE_WR && bsel == BSEL_EXT
    |=> fuse_ext_q == $past(st_ff.dlatch))
    else $error("extended fuse not written");
  a_lock_sticky: assert property (@(posedge sys_clk) disable iff (!rstn) // R6
    !erase_go |=> (lock_q & ~$past(lock_q)) == 8'h00)
    else $error("lock bit cleared without erase");
  a_boot_guard: assert property (@(posedge sys_clk) disable iff (!rstn) // R5
    wr_go && st_ff.cmd == CMD_LOCK_WR && lock_q[1:0] == 2'h0
    |=> lock_q[BOOT_HI_POS:BOOT_LO_POS] == $past(lock_q[BOOT_HI_POS:BOOT_LO_POS]))
    else $error("boot lock bits changed under level three");
  a_erase_lock: assert property (@(posedge sys_clk) disable iff (!rstn) // R17
    erase_go |=> lock_q == LOCK_RST && flash_erase)
    else $error("erase did not reset lock and flash");
  a_oe_release: assert property (@(posedge sys_clk) disable iff (!rstn) // R23
    s_oe_n |=> !data_oe)
    else $error("bus driven with output enable high");
  a_fuse_read: assert property (@(posedge sys_clk) disable iff (!rstn) // R8
    !s_oe_n && s_mode && st_ff.cmd == CMD_FUSE_RD && bsel == BSEL_LOCK
    |=> data_oe && data_out == $past(lock_q))
    else $error("lock byte not shown on readback");
  a_sig_read: assert property (@(posedge sys_clk) disable iff (!rstn) // R9
    st_ff.cmd == CMD_SIG_RD && !s_bsa && st_ff.addr == 8'h01 |=> data_out == SIG_BYTE1)
    else $error("signature byte wrong");
  a_calib_read: assert property (@(posedge sys_clk) disable iff (!rstn) // R10
    st_ff.cmd == CMD_SIG_RD && s_bsa && st_ff.addr == 8'h00 |=> data_out == CALIB_RST)
    else $error("calibration byte wrong");
  a_ser_gate: assert property (@(posedge sys_clk) disable iff (!rstn) // R15
    tg_evt && ser_mode && !st_ff.spi_en && b1 == SER_EE_WR |-> !ee_wr_go)
    else $error("serial write taken before enable");
  a_cmd_load: assert property (@(posedge sys_clk) disable iff (!rstn) // R20
    ls_rise && s_mode && act == ACT_CMD |=> st_ff.cmd == $past(s_data))
    else $error("command not captured");
endmodule

// *** verification/npp_spi_programmer.sv ***
`timescale 1ns/1ps
// ==========================================================
// Serial programmer model
module npp_spi_programmer (
  // Serial pins
  output logic spi_sck,
  output logic spi_mosi,
  input wire logic spi_miso
);
  logic link_ref;
  logic [31:0] rx_word;

  initial begin
    link_ref = 1'b0;
    rx_word = '0;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
    #3;
    forever #15 link_ref = ~link_ref;
  end

  // ==========================================================
  // Word sender, MSB first, clock still between words
  task automatic send_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      @(negedge link_ref);
      spi_mosi = w[i];
      repeat (2) @(posedge link_ref);
      rx_word = {rx_word[30:0], spi_miso};
      spi_sck = 1'b1;
      repeat (2) @(posedge link_ref);
      spi_sck = 1'b0;
    end
    @(negedge link_ref);
    spi_mosi = ~w[0];
  endtask
endmodule

// *** verification/test_npp_prog_port.sv ***
`timescale 1ns/1ps
// ==========================================================
// Bench of the programming port
module test_npp_prog_port;
  import npp_pkg::*;

  localparam int WR_N_CYC = 20;
  localparam int CE_N_CYC = 40;

  logic sys_clk = 1'b0;
  logic rstn;
  logic spi_sck;
  logic spi_mosi;
  logic spi_miso;
  logic prog_mode;
  logic load_strobe;
  logic wr_n;
  logic oe_n;
  logic action_select_hi;
  logic action_select_lo;
  logic byte_select_a;
  logic byte_select_b;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic data_oe;
  logic ready_flag;
  logic prog_reset_n;
  logic [EE_AW-1:0] ee_rd_addr;
  logic [7:0] ee_rd_data;
  logic flash_erase;
  logic [7:0] fuse_low_q;
  logic [7:0] fuse_high_q;
  logic [7:0] fuse_ext_q;
  logic [7:0] lock_q;
  int mismatches = 0;
  int num_checks = 0;
  int erase_cnt = 0;
  logic [7:0] fdat [3] = '{8'hc3, 8'h96, 8'h5a};
  logic [1:0] fsel [3] = '{2'h0, 2'h1, 2'h2};
  logic [7:0] sig [3] = '{SIG_BYTE0, SIG_BYTE1, SIG_BYTE2};

  always #4 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (flash_erase === 1'b1) erase_cnt <= erase_cnt + 1;
  end

  npp_prog_port #(.WR_CYC(WR_N_CYC), .CE_CYC(CE_N_CYC)) npp_prog_port_inst (
    .sys_clk(sys_clk), .rstn(rstn), .spi_sck(spi_sck), .prog_mode(prog_mode),
    .load_strobe(load_strobe), .wr_n(wr_n), .oe_n(oe_n),
    .action_select_hi(action_select_hi), .action_select_lo(action_select_lo),
    .byte_select_a(byte_select_a), .byte_select_b(byte_select_b), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .ready_flag(ready_flag),
    .prog_reset_n(prog_reset_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .ee_rd_addr(ee_rd_addr), .ee_rd_data(ee_rd_data), .flash_erase(flash_erase),
    .fuse_low_q(fuse_low_q), .fuse_high_q(fuse_high_q), .fuse_ext_q(fuse_ext_q),
    .lock_q(lock_q)
  );

  npp_spi_programmer npp_spi_programmer_inst (
    .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso)
  );

  // ==========================================================
  // Verdict and compare
  task automatic finish_test;
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // Access tasks
  task automatic load(input logic [1:0] act, input logic [7:0] d);
    @(negedge sys_clk);
    {action_select_hi, action_select_lo} = act;
    byte_select_a = 1'b0;
    data_in = d;
    repeat (2) @(negedge sys_clk);
    load_strobe = 1'b1;
    repeat (5) @(negedge sys_clk);
    load_strobe = 1'b0;
    repeat (5) @(negedge sys_clk);
  endtask

  task automatic wr_pulse(input int n);
    int t_lo;
    int t_hi;
    t_lo = 0;
    t_hi = 0;
    @(negedge sys_clk);
    wr_n = 1'b0;
    for (int c = 1; c < n + 100 && t_hi == 0; c++) begin
      @(negedge sys_clk);
      if (c == 20) wr_n = 1'b1;
      if (t_lo == 0 && ready_flag === 1'b0) t_lo = c;
      if (t_lo != 0 && ready_flag === 1'b1) t_hi = c;
    end
    wr_n = 1'b1;
    check(8'(t_lo > 0 && t_lo <= WLRL_MAX_CYC), 8'h01);
    check(8'(t_hi >= n && t_hi <= n + 8), 8'h01);
  endtask

  task automatic rd(input logic [1:0] bsel, input logic [7:0] exp);
    @(negedge sys_clk);
    {byte_select_b, byte_select_a} = bsel;
    oe_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    check(8'(data_oe), 8'h01);
    check(data_out, exp);
    oe_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    check(8'(data_oe), 8'h00);
    {byte_select_b, byte_select_a} = 2'h0;
  endtask

  task automatic ser(input logic [31:0] w);
    npp_spi_programmer_inst.send_word(w);
    repeat (8) @(negedge sys_clk);
    for (int i = 0; i < CE_N_CYC + 100 && ready_flag !== 1'b1; i++) @(negedge sys_clk);
    check(8'(ready_flag), 8'h01);
  endtask

  task automatic ee_chk(input logic [EE_AW-1:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    ee_rd_addr = a;
    repeat (3) @(negedge sys_clk);
    check(ee_rd_data, exp);
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    #400000;
    mismatches++;
    finish_test;
  end

  // ==========================================================
  // Main sequence
  initial begin
    int n;
    rstn = 1'b0;
    prog_mode = 1'b0;
    load_strobe = 1'b0;
    wr_n = 1'b1;
    oe_n = 1'b1;
    action_select_hi = 1'b0;
    action_select_lo = 1'b0;
    byte_select_a = 1'b0;
    byte_select_b = 1'b0;
    data_in = 8'h00;
    prog_reset_n = 1'b1;
    ee_rd_addr = '0;
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (3) @(negedge sys_clk);
    check(8'(ready_flag), 8'h01);
    check(lock_q, LOCK_RST);
    check(fuse_ext_q, FUSE_EXT_RST);
    prog_mode = 1'b1;
    repeat (4) @(negedge sys_clk);
    for (int i = 0; i < 3; i++) begin
      load(ACT_CMD, CMD_FUSE_WR);
      load(ACT_DATA, fdat[i]);
      @(negedge sys_clk);
      {byte_select_b, byte_select_a} = fsel[i];
      wr_pulse(WR_N_CYC);
      @(negedge sys_clk);
      {byte_select_b, byte_select_a} = 2'h0;
    end
    check(fuse_low_q, 8'hc3);
    check(fuse_high_q, 8'h96);
    check(fuse_ext_q, 8'h5a);
    load(ACT_CMD, CMD_LOCK_WR);
    load(ACT_DATA, 8'hfc);
    wr_pulse(WR_N_CYC);
    check(lock_q, 8'hfc);
    load(ACT_DATA, 8'hc3);
    wr_pulse(WR_N_CYC);
    check(lock_q, 8'hfc);
    load(ACT_CMD, CMD_FUSE_RD);
    rd(BSEL_LOW, 8'hc3);
    rd(BSEL_HIGH, 8'h96);
    rd(BSEL_EXT, 8'h5a);
    rd(BSEL_LOCK, 8'hfc);
    load(ACT_CMD, CMD_SIG_RD);
    for (int i = 0; i < 3; i++) begin
      load(ACT_ADDR, 8'(i));
      rd(BSEL_LOW, sig[i]);
    end
    load(ACT_ADDR, 8'h00);
    rd(2'h1, CALIB_RST);
    n = erase_cnt;
    load(ACT_CMD, CMD_CHIP_ERASE);
    wr_pulse(CE_N_CYC);
    check(lock_q, ERASED_BYTE);
    check(fuse_ext_q, 8'h5a);
    check(8'(erase_cnt - n), 8'h01);
    // Serial download
    prog_mode = 1'b0;
    @(negedge sys_clk);
    prog_reset_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    ser({SER_EE_WR, 8'h00, 8'h05, 8'ha5});
    ee_chk(5'h05, ERASED_BYTE);
    ser({SER_PREFIX, SER_EN_B2, 16'h0000});
    check(npp_spi_programmer_inst.rx_word[15:8], SER_EN_B2);
    ser({SER_EE_WR, 8'h00, 8'h05, 8'ha5});
    ee_chk(5'h05, 8'ha5);
    ser({SER_EE_WR, 8'h00, 8'h05, 8'h5a});
    ee_chk(5'h05, 8'h5a);
    ser({SER_PREFIX, 8'h80, 16'h0000});
    ee_chk(5'h05, ERASED_BYTE);
    check(8'(erase_cnt - n), 8'h02);
    @(negedge sys_clk);
    prog_reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    ser({SER_EE_WR, 8'h00, 8'h06, 8'h11});
    ee_chk(5'h06, ERASED_BYTE);
    finish_test;
  end
endmodule
